// ===== imsc_regs.vh
// register map, field positions and constants of the stop and baud block
`ifndef IMSC_REGS_VH
`define IMSC_REGS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define IMSC_OFS_CTRL     12'h000
`define IMSC_OFS_RELOAD   12'h004
`define IMSC_OFS_BUF      12'h008
`define IMSC_OFS_CMD      12'h00C
`define IMSC_OFS_STATUS   12'h010
`define IMSC_OFS_MASK     12'h014
`define IMSC_OFS_STATE    12'h018

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define IMSC_CTRL_MODE_LSB 0
`define IMSC_CTRL_MODE_MSB 3
`define IMSC_CTRL_EN_BIT   4
`define IMSC_CMD_STOP_BIT  0
`define IMSC_ST_BCOL_BIT   0
`define IMSC_ST_STOP_BIT   1
`define IMSC_ST_CLKD_BIT   2

// ----------------------------------------------------------------
// reset values and codes
// ----------------------------------------------------------------
`define IMSC_CTRL_RST     5'h00
`define IMSC_RELOAD_RST   8'h00
`define IMSC_MASK_RST     3'h0
`define IMSC_MODE_I2C_M   4'h8
`define IMSC_MODE_SPI_M   4'hA

// ----------------------------------------------------------------
// timing counts
// ----------------------------------------------------------------
`define IMSC_HALVES       5'h12
`define IMSC_PRESCALE     1'h1

`endif

// ===== imsc_baud_counter.v
// reload-driven down counter that times the serial clock halves
`timescale 1ns/1ps
module imsc_baud_counter (
   // clock and reset
   input  wire       sys_clk,
   input  wire       resetn,
   // control
   input  wire       load,
   input  wire       run,
   input  wire [7:0] reload,
   // result
   output reg        expired,
   output reg  [7:0] count
);
`include "imsc_regs.vh"

   reg pre; // divide-by-two prescaler

   // ----------------------------------------------------------------
   // count down every second clock, pulse on reaching zero
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pre     <= 1'h0;
         count   <= 8'h00;
         expired <= 1'h0;
      end else begin
         expired <= 1'h0;
         if (load) begin
            // reload; first step on the next clock keeps the half exact
            count <= reload;
            pre   <= 1'h1;
         end else if (run) begin
            // one step per two system clocks
            pre <= ~pre;
            if (pre == `IMSC_PRESCALE) begin
               if (count != 8'h00) begin
                  count <= count - 8'h01;
               end
            end else if (count == 8'h00) begin
               // zero on the idle step: pulse ends the half at 2*(reload+1)
               expired <= 1'h1;
            end
         end
      end
   end
endmodule

// ===== imsc_stop_brg.v
// stop condition with collision checks, baud counter and apb registers
`timescale 1ns/1ps
// Functional notes
// - sample data low after timeout: collision
// - clock low before data rises: collision
// - drive data low, then release clock
// - wait clock high, load, count down
// - one counter clocks both master modes
// - buffer write starts the counter
// - counter stops, clock pin holds level
// - reload twice per serial clock period
// - rate is oscillator over four(reload+1)
// - collision sets flag, port goes idle
// - collision aborts, releases lines, clears request
module imsc_stop_brg (
   // clock and reset
   input  wire        sys_clk,
   input  wire        resetn,
   // apb slave
   input  wire        psel,
   input  wire        penable,
   input  wire        pwrite,
   input  wire [11:0] paddr,
   input  wire [31:0] pwdata,
   output reg  [31:0] prdata,
   output reg         pready,
   output reg         pslverr,
   // bus data pin
   input  wire        bus_data_pin_in,
   output reg         bus_data_pin_out,
   output reg         bus_data_pin_oe,
   // bus clock pin
   input  wire        bus_clock_pin_in,
   output reg         bus_clock_pin_out,
   output reg         bus_clock_pin_oe,
   // interrupt
   output reg         irq
);
`include "imsc_regs.vh"

   // ----------------------------------------------------------------
   // states
   // ----------------------------------------------------------------
   localparam [2:0] ST_IDLE  = 3'h0; // nothing in progress
   localparam [2:0] ST_CLK   = 3'h1; // free clocking after buffer write
   localparam [2:0] ST_SDALO = 3'h2; // data driven low, wait for it
   localparam [2:0] ST_SCLR  = 3'h3; // clock released, wait high
   localparam [2:0] ST_SCLHI = 3'h4; // clock high, counting
   localparam [2:0] ST_SDAR  = 3'h5; // data released, counting
   // codes six and seven are unused and fall back to idle

   // ----------------------------------------------------------------
   // registers and state
   // ----------------------------------------------------------------
   reg  [4:0] port_control;          // mode and enable
   reg  [7:0] reload_value_register; // counter reload
   reg  [7:0] transfer_buffer;       // last byte written while idle
   reg        stop_request_bit;      // stop requested
   reg  [2:0] status;                // sticky events
   reg  [2:0] mask;                  // interrupt enables
   reg  [2:0] state;                 // sequence state
   reg  [4:0] halves;                // clock halves left
   reg        brg_load;              // reload strobe
   reg        brg_run;               // counter running
   reg        ev_bcol;               // collision event pulse
   reg        ev_stop;               // stop done pulse
   reg        ev_clkd;               // clocking done pulse
   wire       brg_exp;               // counter timeout pulse
   wire [7:0] brg_count;             // counter value

   // ----------------------------------------------------------------
   // apb decode
   // ----------------------------------------------------------------
   // every write lands only on the completing edge of an access
   wire       acc    = psel & penable & pready; // completing access
   wire       wr     = acc & pwrite;
   wire       en     = port_control[`IMSC_CTRL_EN_BIT];
   wire [3:0] mode   = port_control[`IMSC_CTRL_MODE_MSB:`IMSC_CTRL_MODE_LSB];
   wire       i2c_m  = en & (mode == `IMSC_MODE_I2C_M);
   wire       spi_m  = en & (mode == `IMSC_MODE_SPI_M);
   wire       mst    = i2c_m | spi_m;
   wire       buf_wr = wr & (paddr == `IMSC_OFS_BUF);
   wire       cmd_wr = wr & (paddr == `IMSC_OFS_CMD);
   wire       hit    = (paddr == `IMSC_OFS_CTRL)   | (paddr == `IMSC_OFS_RELOAD) |
                       (paddr == `IMSC_OFS_BUF)    | (paddr == `IMSC_OFS_CMD)    |
                       (paddr == `IMSC_OFS_STATUS) | (paddr == `IMSC_OFS_MASK)   |
                       (paddr == `IMSC_OFS_STATE);

   // ----------------------------------------------------------------
   // baud rate counter
   // ----------------------------------------------------------------
   // one counter serves both master modes, reloaded per half
   // its expiry pulse lands on the cycle that ends the half
   imsc_baud_counter u_brg (
      .sys_clk (sys_clk),
      .resetn  (resetn),
      .load    (brg_load),
      .run     (brg_run),
      .reload  (reload_value_register),
      .expired (brg_exp),
      .count   (brg_count)
   );

   // ----------------------------------------------------------------
   // apb handshake: one wait state, unmapped address errors
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         pready  <= 1'h0;
         pslverr <= 1'h0;
         prdata  <= 32'h0000_0000;
      end else begin
         // answer in the second access cycle, one wait state
         // ~pready keeps a held access from answering twice
         pready  <= psel & penable & ~pready;
         pslverr <= psel & penable & ~pready & ~hit;
         if (psel & penable & ~pready & ~pwrite) begin
            // read mux
            case (paddr)
               `IMSC_OFS_CTRL:   prdata <= {27'h0, port_control};
               `IMSC_OFS_RELOAD: prdata <= {24'h0, reload_value_register};
               `IMSC_OFS_BUF:    prdata <= {24'h0, transfer_buffer};
               `IMSC_OFS_CMD:    prdata <= {31'h0, stop_request_bit};
               `IMSC_OFS_STATUS: prdata <= {29'h0, status};
               `IMSC_OFS_MASK:   prdata <= {29'h0, mask};
               `IMSC_OFS_STATE:  prdata <= {16'h0, brg_count, 3'h0,
                                            brg_run, 1'h0, state};
               default:          prdata <= 32'h0000_0000;
            endcase
         end
      end
   end

   // ----------------------------------------------------------------
   // plain software registers
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         port_control          <= `IMSC_CTRL_RST;
         reload_value_register <= `IMSC_RELOAD_RST;
         mask                  <= `IMSC_MASK_RST;
         transfer_buffer       <= 8'h00;
      end else begin
         if (wr & (paddr == `IMSC_OFS_CTRL)) begin
            port_control <= pwdata[4:0];
         end
         if (wr & (paddr == `IMSC_OFS_RELOAD)) begin
            // values below three are not usable on the two-wire bus
            reload_value_register <= pwdata[7:0];
         end
         if (wr & (paddr == `IMSC_OFS_MASK)) begin
            mask <= pwdata[2:0];
         end
         // a busy sequencer leaves the buffer unchanged
         if (buf_wr & (state == ST_IDLE)) begin
            transfer_buffer <= pwdata[7:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // sticky status, write one to clear, set wins
   // ----------------------------------------------------------------
   // status and mask share this bit layout
   wire [2:0] ev_set = {ev_clkd, ev_stop, ev_bcol};
   wire [2:0] w1c    = (wr & (paddr == `IMSC_OFS_STATUS)) ? pwdata[2:0] : 3'h0;

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_status
         // one sticky bit per event
         always @(posedge sys_clk or negedge resetn) begin
            if (!resetn) begin
               status[gi] <= 1'h0;
            end else if (ev_set[gi]) begin
               status[gi] <= 1'h1;
            end else if (w1c[gi]) begin
               status[gi] <= 1'h0;
            end
         end
      end
   endgenerate

   // ----------------------------------------------------------------
   // interrupt output
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         irq <= 1'h0;
      end else begin
         // events are or-ed in so the pin rises with the status bit
         irq <= |((status | ev_set) & mask);
      end
   end

   // ----------------------------------------------------------------
   // stop and clocking sequencer
   // ----------------------------------------------------------------
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         state             <= ST_IDLE;
         halves            <= 5'h00;
         stop_request_bit  <= 1'h0;
         brg_load          <= 1'h0;
         brg_run           <= 1'h0;
         ev_bcol           <= 1'h0;
         ev_stop           <= 1'h0;
         ev_clkd           <= 1'h0;
         bus_data_pin_out  <= 1'h0;
         bus_data_pin_oe   <= 1'h0;
         bus_clock_pin_out <= 1'h0;
         bus_clock_pin_oe  <= 1'h0;
      end else begin
         // pulses and the reload strobe last one clock
         brg_load <= 1'h0;
         ev_bcol  <= 1'h0;
         ev_stop  <= 1'h0;
         ev_clkd  <= 1'h0;
         // a stop request waits in idle until clocking has ended
         // outside two-wire master mode the request is refused
         if (cmd_wr & pwdata[`IMSC_CMD_STOP_BIT] & i2c_m) begin
            stop_request_bit <= 1'h1;
         end
         if (!en) begin
            // disabled: port idle, both lines free
            state            <= ST_IDLE;
            brg_run          <= 1'h0;
            stop_request_bit <= 1'h0;
            bus_data_pin_oe  <= 1'h0;
            bus_clock_pin_oe <= 1'h0;
         end else begin
            case (state)
               // idle: a stop request wins over a buffer write
               ST_IDLE: begin
                  brg_run <= 1'h0;
                  if (stop_request_bit) begin
                     // begin with data low, clock held low
                     bus_data_pin_oe  <= 1'h1;
                     bus_clock_pin_oe <= 1'h1;
                     state            <= ST_SDALO;
                  end else if (buf_wr & mst) begin
                     // buffer write kicks the counter off
                     brg_load         <= 1'h1;
                     brg_run          <= 1'h1;
                     halves           <= `IMSC_HALVES;
                     bus_clock_pin_oe <= 1'h1;
                     state            <= ST_CLK;
                  end
               end

               // clocking: each expiry ends one half of the clock
               ST_CLK: begin
                  if (brg_exp) begin
                     // one rollover per half period
                     brg_load <= 1'h1;
                     halves   <= halves - 5'h01;
                     if (halves == 5'h01) begin
                        // done: counter stops, pin keeps level
                        brg_run <= 1'h0;
                        ev_clkd <= 1'h1;
                        state   <= ST_IDLE;
                     end else begin
                        bus_clock_pin_oe <= ~bus_clock_pin_oe;
                     end
                  end else if (i2c_m & ~bus_clock_pin_oe & ~bus_clock_pin_in) begin
                     // clock stretched by a slave: hold the count
                     // the half restarts once the line is let go
                     brg_load <= 1'h1;
                  end
               end

               // stop: wait until data really reads low
               ST_SDALO: begin
                  if (!bus_data_pin_in) begin
                     // data seen low: let clock float
                     bus_clock_pin_oe <= 1'h0;
                     state            <= ST_SCLR;
                  end
               end

               // stop: a slave may stretch the clock here
               ST_SCLR: begin
                  if (bus_clock_pin_in) begin
                     // clock really high: time the first half
                     brg_load <= 1'h1;
                     brg_run  <= 1'h1;
                     state    <= ST_SCLHI;
                  end
               end

               // stop: first half with the clock high
               ST_SCLHI: begin
                  if (!bus_clock_pin_in) begin
                     // clock pulled low before data rose
                     ev_bcol          <= 1'h1;
                     stop_request_bit <= 1'h0;
                     bus_data_pin_oe  <= 1'h0;
                     brg_run          <= 1'h0;
                     state            <= ST_IDLE;
                  end else if (brg_exp) begin
                     // release data, time the second half
                     bus_data_pin_oe <= 1'h0;
                     brg_load        <= 1'h1;
                     state           <= ST_SDAR;
                  end
               end

               // stop: second half with data released
               ST_SDAR: begin
                  if (!bus_clock_pin_in & !bus_data_pin_in) begin
                     // clock lost while data still low
                     // data not yet high, so another master drives a zero
                     ev_bcol          <= 1'h1;
                     stop_request_bit <= 1'h0;
                     brg_run          <= 1'h0;
                     state            <= ST_IDLE;
                  end else if (brg_exp) begin
                     brg_run          <= 1'h0;
                     stop_request_bit <= 1'h0;
                     state            <= ST_IDLE;
                     if (!bus_data_pin_in) begin
                        // another master holds data low
                        ev_bcol <= 1'h1;
                     end else begin
                        ev_stop <= 1'h1;
                     end
                  end
               end

               // illegal code: back to idle, lines free
               default: begin
                  state            <= ST_IDLE;
                  brg_run          <= 1'h0;
                  bus_data_pin_oe  <= 1'h0;
                  bus_clock_pin_oe <= 1'h0;
               end
            endcase
         end
      end
   end
endmodule

// ===== imsc_stop_brg_assertions.sv
// checker of stop timing, baud halves and register bus answers
`timescale 1ns/1ps
module imsc_stop_brg_assertions (
   // clock and reset
   input wire        sys_clk,
   input wire        resetn,
   // apb slave
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   input wire [31:0] prdata,
   input wire        pready,
   input wire        pslverr,
   // bus pins
   input wire        bus_data_pin_in,
   input wire        bus_data_pin_out,
   input wire        bus_data_pin_oe,
   input wire        bus_clock_pin_in,
   input wire        bus_clock_pin_out,
   input wire        bus_clock_pin_oe,
   // interrupt
   input wire        irq
);
   // ----------------------------------------------------------------
   // helper logic
   // ----------------------------------------------------------------
   reg  [7:0] rl;                                  // shadow of reload value
   reg  [9:0] hc;                                  // cycles since clock oe changed
   reg  [9:0] sc;                                  // cycles since clock line rose
   reg        arm;                                 // buffer write seen
   reg        tgl;                                 // clocking under way
   wire       wr = psel & penable & pready & pwrite; // completed write
   wire [9:0] lo = {1'b0, rl, 1'b0} + 10'h001;     // shortest half
   // track reload and half lengths
   always @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         rl  <= 8'h00;
         hc  <= 10'h000;
         sc  <= 10'h000;
         arm <= 1'b0;
         tgl <= 1'b0;
      end else begin
         if (wr && paddr == 12'h004) rl <= pwdata[7:0];
         hc <= $changed(bus_clock_pin_oe) ? 10'h000 : hc + {9'h000, hc != 10'h3FF};
         sc <= $rose(bus_clock_pin_in) ? 10'h000 : sc + {9'h000, sc != 10'h3FF};
         // a buffer write rearms, no clock oe edge for lo plus 16 cycles means clocking is over
         if (wr && paddr == 12'h008) begin
            arm <= 1'b1;
            tgl <= 1'b0;
         end else if (arm && $changed(bus_clock_pin_oe)) tgl <= 1'b1;
         else if (hc > lo + 10'h010) begin
            arm <= 1'b0;
            tgl <= 1'b0;
         end
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);
   // ----------------------------------------------------------------
   // properties
   // ----------------------------------------------------------------
   a_apb_one_wait: assert property ($rose(penable) && psel |-> !pready ##1 pready)
      else $error("pready not in second access cycle");
   a_pins_open_drain: assert property (!bus_data_pin_out && !bus_clock_pin_out)
      else $error("pin driven high");
   a_stop_both_low: assert property ($rose(bus_data_pin_oe) |-> bus_clock_pin_oe)
      else $error("data pulled with clock free");
   a_clk_after_data: assert property ($fell(bus_clock_pin_oe) && bus_data_pin_oe
      |-> !$past(bus_data_pin_in)) else $error("clock freed before data low");
   a_clk_drop_abort: assert property (bus_data_pin_oe && !bus_clock_pin_oe
      && $fell(bus_clock_pin_in) |-> ##[1:4] !bus_data_pin_oe) else $error("no abort");
   a_half_timing: assert property ($changed(bus_clock_pin_oe) && tgl
      |-> hc >= lo && hc <= lo + 10'h005) else $error("half length wrong");
   a_stop_half: assert property ($fell(bus_data_pin_oe) && bus_clock_pin_in
      |-> sc >= lo && sc <= lo + 10'h008) else $error("stop half wrong");
   a_irq_lines_free: assert property ($rose(irq)
      |-> !bus_data_pin_oe && !bus_clock_pin_oe) else $error("lines held at event");
endmodule
bind imsc_stop_brg imsc_stop_brg_assertions chk (.sys_clk(sys_clk), .resetn(resetn),
   .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus_data_pin_in(bus_data_pin_in),
   .bus_data_pin_out(bus_data_pin_out), .bus_data_pin_oe(bus_data_pin_oe),
   .bus_clock_pin_in(bus_clock_pin_in), .bus_clock_pin_out(bus_clock_pin_out),
   .bus_clock_pin_oe(bus_clock_pin_oe), .irq(irq));

// ===== imsc_bus_model.sv
// other masters and slaves on the two-wire bus, lines with pull-ups
`timescale 1ns/1ps
module imsc_bus_model (
   // pulls of the block
   input  wire dat_oe,
   input  wire clk_oe,
   // pulls of other parties
   input  wire hold_dat,
   input  wire hold_clk,
   // resolved levels
   output wire dat_line,
   output wire clk_line
);
   // wired-and: pull-up unless someone pulls low, hold_clk stretches
   assign dat_line = !(dat_oe | hold_dat);
   assign clk_line = !(clk_oe | hold_clk);
endmodule

// ===== imsc_stop_brg_test.sv
// self-checking bench of the stop and baud block
`timescale 1ns/1ps
`include "imsc_regs.vh"
module imsc_stop_brg_test;
   // ----------------------------------------------------------------
   // signals
   // ----------------------------------------------------------------
   reg         sys_clk = 1'b0;
   reg         resetn = 1'b0;
   reg         psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   reg  [11:0] paddr = 12'h000;
   reg  [31:0] pwdata = 32'h0;
   wire [31:0] prdata;
   wire        pready, pslverr, irq, d_oe, c_oe, d_ln, c_ln;
   reg         hold_dat = 1'b0, hold_clk = 1'b0;
   reg  [31:0] rd;                    // last read word
   reg         er;                    // last error answer
   reg  [7:0]  tog = 8'h00;           // clock oe changes
   reg         c_q = 1'b0;            // clock oe one cycle back
   integer     error_cnt = 0, total_checks = 0, i, n;
   // rows: mode, reload
   localparam [47:0] ROWS = {4'hA, 8'h04, 4'hA, 8'h01, 4'h8, 8'h13, 4'h8, 8'h03};
   always #12.5 sys_clk = ~sys_clk;
   // count clock oe changes
   always @(posedge sys_clk) begin
      c_q <= c_oe;
      if (c_q !== c_oe) tog <= tog + 8'h01;
   end
   imsc_stop_brg uut (.sys_clk(sys_clk), .resetn(resetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .bus_data_pin_in(d_ln), .bus_data_pin_out(), .bus_data_pin_oe(d_oe),
      .bus_clock_pin_in(c_ln), .bus_clock_pin_out(), .bus_clock_pin_oe(c_oe), .irq(irq));
   imsc_bus_model bus (.dat_oe(d_oe), .clk_oe(c_oe), .hold_dat(hold_dat),
      .hold_clk(hold_clk), .dat_line(d_ln), .clk_line(c_ln));
   // ----------------------------------------------------------------
   // tasks
   // ----------------------------------------------------------------
   task chk(input string nm, input [31:0] got, input [31:0] exp);
      begin
         total_checks = total_checks + 1;
         if (got !== exp) begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0s expected %h seen %h", nm, exp, got);
         end
      end
   endtask
   // one apb transfer, waits for pready
   task apb(input w, input [11:0] a, input [31:0] d);
      begin
         @(posedge sys_clk);
         psel <= 1'b1;
         pwrite <= w;
         paddr <= a;
         pwdata <= d;
         @(posedge sys_clk);
         penable <= 1'b1;
         @(posedge sys_clk);
         while (pready !== 1'b1) @(posedge sys_clk);
         rd = prdata;
         er = pslverr;
         psel <= 1'b0;
         penable <= 1'b0;
      end
   endtask
   // poll status until an event shows
   task wait_st;
      begin
         rd = 32'h0;
         while (rd[2:0] == 3'h0) apb(1'b0, `IMSC_OFS_STATUS, 32'h0);
      end
   endtask
   // stop sequence: 0 stretched, 1 data held, 2 clock pulled
   task stop_run(input [1:0] sel, input [2:0] ex);
      begin
         hold_dat <= (sel == 2'h1);
         hold_clk <= (sel == 2'h0);
         apb(1'b1, `IMSC_OFS_CMD, 32'h1);
         if (sel == 2'h0) begin
            repeat (40) @(posedge sys_clk);
            chk("stretch", {d_oe, c_ln}, 2'h2);
            hold_clk <= 1'b0;
         end
         n = 0;
         while (sel == 2'h2 && !(d_oe && !c_oe && c_ln) && n < 500) begin
            @(posedge sys_clk);
            n = n + 1;
         end
         if (sel == 2'h2) hold_clk <= 1'b1;
         wait_st;
         chk("stop status", rd, {29'h0, ex});
         apb(1'b0, `IMSC_OFS_CMD, 32'h0);
         chk("request", rd, 32'h0);
         chk("lines", {d_oe, c_oe}, 2'h0);
         hold_dat <= 1'b0;
         hold_clk <= 1'b0;
      end
   endtask
   task finish_test;
      begin
         $display("checks %0d errors %0d", total_checks, error_cnt);
         if (error_cnt == 0 && total_checks > 0) $display("No errors found");
         else $display("Errors were found");
         $finish;
      end
   endtask
   // watchdog
   initial begin
      #2000000;
      error_cnt = error_cnt + 1;
      $display("watchdog expired");
      finish_test;
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (8) @(posedge sys_clk);
      resetn <= 1'b1;
      // clocking in both master modes, one counter
      apb(1'b1, `IMSC_OFS_MASK, 32'h7);
      for (i = 0; i < 4; i = i + 1) begin
         apb(1'b1, `IMSC_OFS_CTRL, {27'h0, 1'b1, ROWS[i*12+8 +: 4]});
         apb(1'b1, `IMSC_OFS_RELOAD, {24'h0, ROWS[i*12 +: 8]});
         n = tog;
         apb(1'b1, `IMSC_OFS_BUF, 32'h000000A5);
         wait_st;
         chk("status", rd, 32'h4);
         chk("edges", tog - n, {27'h0, `IMSC_HALVES});
         chk("clock free", {irq, c_oe, c_ln}, 3'h5);
         apb(1'b1, `IMSC_OFS_STATUS, 32'h4);
      end
      // reset values and an unmapped place
      resetn <= 1'b0;
      @(posedge sys_clk);
      resetn <= 1'b1;
      apb(1'b0, `IMSC_OFS_CTRL, 32'h0);
      chk("ctrl", rd, {27'h0, `IMSC_CTRL_RST});
      apb(1'b0, `IMSC_OFS_RELOAD, 32'h0);
      chk("reload", rd, {24'h0, `IMSC_RELOAD_RST});
      apb(1'b0, `IMSC_OFS_MASK, 32'h0);
      chk("mask", rd, {29'h0, `IMSC_MASK_RST});
      apb(1'b1, 12'h01C, 32'hFFFFFFFF);
      chk("unmapped wr err", {31'h0, er}, 32'h1);
      apb(1'b0, 12'h01C, 32'h0);
      chk("unmapped rd err", {31'h0, er}, 32'h1);
      chk("unmapped data", rd, 32'h0);
      // stop refused outside two-wire master mode
      apb(1'b1, `IMSC_OFS_CTRL, 32'h1A);
      apb(1'b1, `IMSC_OFS_CMD, 32'h1);
      apb(1'b0, `IMSC_OFS_CMD, 32'h0);
      chk("spi stop", rd, 32'h0);
      // stop with stretching, event masked then unmasked
      apb(1'b1, `IMSC_OFS_CTRL, 32'h18);
      apb(1'b1, `IMSC_OFS_RELOAD, 32'h4);
      apb(1'b1, `IMSC_OFS_MASK, 32'h1);
      stop_run(2'h0, 3'h2);
      chk("masked", irq, 1'b0);
      apb(1'b1, `IMSC_OFS_MASK, 32'h7);
      apb(1'b0, `IMSC_OFS_STATUS, 32'h0);
      chk("unmasked", irq, 1'b1);
      // both collision cases
      for (i = 1; i < 4; i = i + 1) begin
         apb(1'b1, `IMSC_OFS_STATUS, 32'h7);
         apb(1'b0, `IMSC_OFS_STATUS, 32'h0);
         chk("cleared", rd, 32'h0);
         chk("irq low", {31'h0, irq}, 32'h0);
         if (i < 3) stop_run(i[1:0], 3'h1);
      end
      finish_test;
   end
endmodule
